// [rsp_bank.sv]
`timescale 1ns/1ns
module rsp_bank
(
  input wire logic i_sys_clk, // System clock, 50 MHz.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire rsp_pkg::rsp_events_t i_events, // Comparator events, already synchronous.
  input wire rsp_pkg::rsp_rail_t i_rail, // Live rail state, already synchronous.
  input wire rsp_pkg::rsp_phase_t i_phase, // Phase sense bytes.
  input wire logic i_cmd_valid, // Command code strobe from the bus engine.
  input wire logic [7:0] i_cmd_code, // Command code.
  output logic [15:0] o_read_data, // Read data for the last answered read command; held through clears and unknown codes.
  output logic o_read_valid, // Read data valid, one cycle.
  output logic o_cmd_unknown, // Unsupported code seen, one cycle.
  output logic o_rail_shutdown, // Shutdown request from sense faults.
  output logic o_monitor_reset, // Monitor machine and timer reset pulse.
  output logic o_rail_ready_output // Ready pin level.
);
  import rsp_pkg::*;

  // ==========================================================================
  // Clear command decode.
  // ==========================================================================
  wire clear_cmd = i_cmd_valid && (i_cmd_code == CMD_CLEAR_FAULTS);

  // ==========================================================================
  // Detail latches: set wins over clear so no event is lost.
  // ==========================================================================
  logic [7:0] vout_reg, vout_next;
  logic [7:0] iout_reg, iout_next;
  logic [4:0] misc_reg, misc_next; // Input uv, other input, temp, cml, io low.
  logic wdog_reg, wdog_next;
  wire code_out_of_window = (i_rail.code > i_rail.code_max) || (i_rail.code < i_rail.code_min);
  logic [7:0] vout_set, iout_set;

  // Event vectors placed at their detail bit positions.
  always_comb
  begin
    vout_set = ZERO_BYTE;
    vout_set[VO_OV] = i_events.ov;
    vout_set[VO_UV_WARN] = i_events.uv_warn;
    vout_set[VO_UV_FAULT] = i_events.uv_fault;
    vout_set[VO_MAXMIN] = code_out_of_window;
    vout_set[VO_FLOAT] = i_events.float_line;
    vout_set[VO_GROUNDED] = i_events.grounded;
    iout_set = ZERO_BYTE;
    iout_set[IO_OC] = i_events.oc;
    iout_set[IO_OC_UV] = i_events.oc && i_events.uv_comp;
    iout_set[IO_OC_WARN] = i_events.oc_warn;
    iout_set[IO_POUT_WARN] = i_events.pout_warn;
  end

  // A clear in the same cycle as an event keeps the event.
  assign vout_next = vout_set | (clear_cmd ? ZERO_BYTE : vout_reg);
  assign iout_next = iout_set | (clear_cmd ? ZERO_BYTE : iout_reg);
  assign misc_next = {i_events.vin_uv, i_events.vin_other, i_events.ot, i_events.comm_memory_logic_flag,
                      i_events.io_low} | (clear_cmd ? 5'h00 : misc_reg);
  assign wdog_next = i_events.wdog_ovf | (wdog_reg && !clear_cmd);

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      vout_reg <= ZERO_BYTE;
      iout_reg <= ZERO_BYTE;
      misc_reg <= 5'h00;
      wdog_reg <= 1'b0;
    end
    else
    begin
      vout_reg <= vout_next;
      iout_reg <= iout_next;
      misc_reg <= misc_next;
      wdog_reg <= wdog_next;
    end
  end

  // ==========================================================================
  // Shutdown level and monitor reset pulse.
  // ==========================================================================
  logic shutdown_reg, mon_reset_reg;
  // The sense faults hold the rail down until the host clears them.
  wire shutdown_next = vout_next[VO_FLOAT] || vout_next[VO_GROUNDED];
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      shutdown_reg <= 1'b0;
      mon_reset_reg <= 1'b0;
    end
    else
    begin
      shutdown_reg <= shutdown_next;
      mon_reset_reg <= i_events.wdog_ovf;
    end
  end

  // ==========================================================================
  // Rail ready: boot mode or threshold mode with a microsecond delay.
  // ==========================================================================
  logic rail_off;
  assign rail_off = i_rail.protect_off || !i_rail.enable || (i_rail.code == ZERO_CODE) ||
                    shutdown_reg;
  typedef enum logic [1:0] {RDY_IDLE, RDY_WAIT, RDY_ON} rsp_rdy_t;
  rsp_rdy_t rdy_reg, rdy_next;
  logic [5:0] us_cnt_reg;
  logic [7:0] dly_cnt_reg;
  logic ready_reg, ready_next;
  wire us_tick = (us_cnt_reg == US_LAST);
  wire fault_now = rail_off || i_events.ov || i_events.oc || i_events.uv_fault;
  wire boot_reached = (i_rail.vout_code >= i_rail.boot_code);
  wire above_on = (i_rail.vout_code > i_rail.pg_on);
  wire below_off = (i_rail.vout_code <= i_rail.pg_off);
  wire delay_done = (dly_cnt_reg >= i_rail.pg_delay_us);

  // Next-state logic for the ready machine.
  always_comb
  begin
    rdy_next = rdy_reg;
    if (fault_now)
      rdy_next = RDY_IDLE;
    else if (!i_rail.ready_mode)
      rdy_next = boot_reached ? RDY_ON : rdy_reg;
    else
    begin
      unique case (rdy_reg)
        RDY_IDLE: rdy_next = above_on ? RDY_WAIT : RDY_IDLE;
        RDY_WAIT: rdy_next = !above_on ? RDY_IDLE : (delay_done ? RDY_ON : RDY_WAIT);
        RDY_ON: rdy_next = below_off ? RDY_IDLE : RDY_ON;
      endcase
    end
    ready_next = (rdy_next == RDY_ON);
  end

  // Both counters restart outside the wait state, so a half-spent microsecond left over
  // from before can never cut the programmed delay short.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdy_reg <= RDY_IDLE;
      us_cnt_reg <= 6'h00;
      dly_cnt_reg <= 8'h00;
      ready_reg <= 1'b0;
    end
    else
    begin
      rdy_reg <= rdy_next;
      if (us_tick || rdy_reg != RDY_WAIT)
        us_cnt_reg <= 6'h00;
      else
        us_cnt_reg <= us_cnt_reg + 6'h01;
      if (rdy_reg != RDY_WAIT)
        dly_cnt_reg <= 8'h00;
      else if (us_tick && dly_cnt_reg != 8'hFF)
        dly_cnt_reg <= dly_cnt_reg + 8'h01;
      ready_reg <= ready_next;
    end
  end

  // ==========================================================================
  // Summary byte and word, built from the detail latches, live busy and off state, and the ready level.
  // ==========================================================================
  logic [7:0] summary_byte;
  logic [15:0] summary_word;
  always_comb
  begin
    summary_byte = ZERO_BYTE;
    summary_byte[SB_NVM_BUSY] = i_rail.nvm_busy;
    summary_byte[SB_OFF] = rail_off;
    summary_byte[SB_OV] = vout_reg[VO_OV];
    summary_byte[SB_OC] = iout_reg[IO_OC];
    summary_byte[SB_VIN_UV] = misc_reg[4];
    summary_byte[SB_TEMP] = misc_reg[2];
    summary_byte[SB_CML] = misc_reg[1];
    summary_word = {ZERO_BYTE, summary_byte};
    summary_word[SW_VOUT] = |vout_reg;
    summary_word[SW_IOUT] = |iout_reg;
    summary_word[SW_INPUT] = misc_reg[4] || misc_reg[3];
    summary_word[SW_IO_LOW] = misc_reg[0];
    summary_word[SW_READY] = ready_reg;
    summary_word[SW_WDOG] = wdog_reg;
  end

  // ==========================================================================
  // Read decode.
  // ==========================================================================
  logic [15:0] rd_word;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = ZERO_WORD;
    unique case (i_cmd_code)
      CMD_PHASE_34: rd_word = {i_phase.p4, i_phase.p3};
      CMD_PHASE_56: rd_word = {i_phase.p6, i_phase.p5};
      // Phase 7 reads zero when it serves the other rail.
      CMD_PHASE_7: rd_word = {ZERO_BYTE, i_rail.phase7_on_rail ? i_phase.p7 : ZERO_BYTE};
      CMD_SUMMARY_BYTE: rd_word = {ZERO_BYTE, summary_byte};
      CMD_SUMMARY_WORD: rd_word = summary_word;
      CMD_VOUT_DETAIL: rd_word = {ZERO_BYTE, vout_reg};
      CMD_IOUT_DETAIL: rd_word = {ZERO_BYTE, iout_reg};
      CMD_CLEAR_FAULTS: rd_hit = 1'b0;
      default: rd_hit = 1'b0;
    endcase
  end
  wire unknown = i_cmd_valid && !rd_hit && !clear_cmd;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_read_data <= ZERO_WORD;
      o_read_valid <= 1'b0;
      o_cmd_unknown <= 1'b0;
    end
    else
    begin
      o_read_valid <= i_cmd_valid && rd_hit;
      o_cmd_unknown <= unknown;
      if (i_cmd_valid && rd_hit)
        o_read_data <= rd_word;
    end
  end

  assign o_rail_shutdown = shutdown_reg;
  assign o_monitor_reset = mon_reset_reg;
  assign o_rail_ready_output = ready_reg;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  chk_ov_latch_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.ov |=> vout_reg[VO_OV] && summary_byte[SB_OV])
    else $error("Overvoltage not latched.");
  chk_clear_empties: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (clear_cmd && i_events == '0 && !code_out_of_window) |=> (vout_reg == ZERO_BYTE)
      && (iout_reg == ZERO_BYTE) && !wdog_reg && (misc_reg == 5'h00))
    else $error("Clear did not empty latches.");
  chk_set_beats_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (clear_cmd && i_events.oc) |=> iout_reg[IO_OC])
    else $error("Event lost under clear.");
  chk_word_low_byte: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    summary_word[7:0] == summary_byte)
    else $error("Word low byte differs.");
  chk_oc_uv_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_events.oc && !i_events.uv_comp && !iout_reg[IO_OC_UV] && !clear_cmd)
      |=> !iout_reg[IO_OC_UV])
    else $error("Dual flag set without both causes.");
  chk_ground_shutdown: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.grounded |=> o_rail_shutdown && vout_reg[VO_GROUNDED])
    else $error("Grounded sense did not shut down.");
  chk_wdog_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(i_events.wdog_ovf) |=> o_monitor_reset && wdog_reg)
    else $error("Watchdog overflow not handled.");
  chk_ready_fault: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fault_now |=> !o_rail_ready_output)
    else $error("Ready stays up under fault.");
  chk_phase7_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cmd_valid && i_cmd_code == CMD_PHASE_7 && !i_rail.phase7_on_rail)
      |=> o_read_data == ZERO_WORD)
    else $error("Phase 7 read leaked.");
  chk_busy_live: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    summary_byte[SB_NVM_BUSY] == i_rail.nvm_busy)
    else $error("Busy bit not live.");

  // ==========================================================================
  // Further checks on summary, detail, ready and read paths.
  // ==========================================================================
  // Each latched summary bit must follow its cause one edge later.
  chk_temp_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.ot |=> summary_byte[SB_TEMP])
    else $error("Temperature bit not latched.");
  chk_cml_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.comm_memory_logic_flag |=> summary_byte[SB_CML])
    else $error("Communication bit not latched.");
  chk_vin_uv_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.vin_uv |=> summary_byte[SB_VIN_UV] && summary_word[SW_INPUT])
    else $error("Input undervoltage not latched.");
  chk_input_word: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.vin_other |=> summary_word[SW_INPUT])
    else $error("Input summary bit not latched.");
  chk_iout_word: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_events.oc_warn || i_events.pout_warn) |=> summary_word[SW_IOUT])
    else $error("Output current summary bit not latched.");
  chk_io_low_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.io_low |=> summary_word[SW_IO_LOW])
    else $error("I/O supply bit not latched.");
  chk_vout_word: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.ov |=> summary_word[SW_VOUT])
    else $error("Output voltage summary bit not latched.");
  // Detail bits latch on their own events.
  chk_uv_warn_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.uv_warn |=> vout_reg[VO_UV_WARN])
    else $error("Low output warning not latched.");
  chk_uv_fault_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.uv_fault |=> vout_reg[VO_UV_FAULT])
    else $error("Low output fault not latched.");
  chk_window_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    code_out_of_window |=> vout_reg[VO_MAXMIN])
    else $error("Code window bit not latched.");
  chk_float_shutdown: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_events.float_line |=> o_rail_shutdown && vout_reg[VO_FLOAT])
    else $error("Floating sense did not shut down.");
  chk_oc_uv_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_events.oc && i_events.uv_comp) |=> iout_reg[IO_OC_UV])
    else $error("Dual flag not latched.");
  chk_monitor_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_events.wdog_ovf |=> !o_monitor_reset)
    else $error("Monitor reset without overflow.");
  chk_off_live: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_rail.protect_off || !i_rail.enable || i_rail.code == ZERO_CODE)
      |-> summary_byte[SB_OFF])
    else $error("Off bit not live.");
  // Ready level in both modes.
  chk_boot_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!i_rail.ready_mode && !fault_now && boot_reached) |=> o_rail_ready_output)
    else $error("Boot mode ready missing.");
  chk_thresh_drop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_rail.ready_mode && rdy_reg == RDY_ON && below_off) |=> !o_rail_ready_output)
    else $error("Ready kept below off level.");
  chk_thresh_delay: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ($rose(ready_reg) && $past(i_rail.ready_mode)) |-> dly_cnt_reg >= $past(i_rail.pg_delay_us))
    else $error("Ready rose before the delay.");
  // Read answers carry the right fields.
  chk_phase34_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cmd_valid && i_cmd_code == CMD_PHASE_34)
      |=> o_read_valid && o_read_data == {$past(i_phase.p4), $past(i_phase.p3)})
    else $error("Phase 3 and 4 read wrong.");
  chk_phase56_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cmd_valid && i_cmd_code == CMD_PHASE_56)
      |=> o_read_valid && o_read_data == {$past(i_phase.p6), $past(i_phase.p5)})
    else $error("Phase 5 and 6 read wrong.");
  chk_phase7_pass: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cmd_valid && i_cmd_code == CMD_PHASE_7 && i_rail.phase7_on_rail)
      |=> o_read_data == {ZERO_BYTE, $past(i_phase.p7)})
    else $error("Phase 7 read wrong.");
  chk_word_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cmd_valid && i_cmd_code == CMD_SUMMARY_WORD) |=> o_read_data == $past(summary_word))
    else $error("Status word read wrong.");
  chk_byte_reserved: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cmd_valid && i_cmd_code == CMD_SUMMARY_BYTE)
      |=> o_read_data[15:8] == ZERO_BYTE && !o_read_data[0])
    else $error("Reserved bits not zero.");
  chk_clear_silent: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cmd_valid && i_cmd_code == CMD_CLEAR_FAULTS) |=> !o_read_valid && !o_cmd_unknown)
    else $error("Clear answered like a read.");
  cov_sense_shutdown: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_rail_shutdown));
  cov_clear: cover property (@(posedge i_sys_clk) disable iff (i_rst) clear_cmd && |vout_reg);
  cov_thresh_ready: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rail.ready_mode && $rose(ready_reg));
  cov_boot_ready: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_rail.ready_mode && $rose(ready_reg));
  cov_word_read: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd_code == CMD_SUMMARY_WORD);
endmodule

// [rsp_bank_tb.sv]
`timescale 1ns/1ns
module rsp_bank_tb;
  import rsp_pkg::*;

  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  rsp_events_t ev_in = '0;
  rsp_rail_t rail = '0;
  rsp_phase_t ph = '0;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [15:0] o_read_data;
  logic o_read_valid;
  logic o_cmd_unknown;
  logic o_rail_shutdown;
  logic o_monitor_reset;
  logic o_rail_ready_output;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_cyc = 0;
  logic [17:0] r;
  // One event per row, raised alone, except the last row, which raises oc with uv_comp; then the latched pattern is expected.
  logic [14:0] ev_tab [16] = '{15'h4000, 15'h2000, 15'h1000, 15'h0800, 15'h0400, 15'h0200,
    15'h0100, 15'h0080, 15'h0040, 15'h0020, 15'h0010, 15'h0008, 15'h0004, 15'h0002,
    15'h0001, 15'h2100};
  logic [15:0] wd_tab [16] = '{16'h8020, 16'h4010, 16'h4000, 16'h4000, 16'h8000, 16'h8000,
    16'h0000, 16'h2008, 16'h2000, 16'h0004, 16'h0002, 16'h1000, 16'h0100, 16'h8040,
    16'h8040, 16'h4010};
  logic [7:0] vo_tab [16] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h20, 8'h10, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00};
  logic [7:0] io_tab [16] = '{8'h00, 8'h80, 8'h20, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0};

  // ==========================================================================
  // Clock, design and host.
  // ==========================================================================
  always #10 i_sys_clk = ~i_sys_clk;

  rsp_bank dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_events(ev_in), .i_rail(rail),
    .i_phase(ph), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
    .o_read_data(o_read_data), .o_read_valid(o_read_valid), .o_cmd_unknown(o_cmd_unknown),
    .o_rail_shutdown(o_rail_shutdown), .o_monitor_reset(o_monitor_reset),
    .o_rail_ready_output(o_rail_ready_output));

  rsp_host_model host (.i_sys_clk(i_sys_clk), .i_read_data(o_read_data),
    .i_read_valid(o_read_valid), .i_cmd_unknown(o_cmd_unknown), .o_cmd_valid(cmd_valid),
    .o_cmd_code(cmd_code));

  // ==========================================================================
  // Checking helpers.
  // ==========================================================================
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // A read must answer with the valid pulse and no refusal.
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    logic [17:0] resp;
    host.xfer(code, resp);
    chk(resp, {2'b10, exp});
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // The whole run needs about 470 cycles, so this ceiling only cuts a hang.
  always @(posedge i_sys_clk)
  begin
    n_cyc++;
    if (n_cyc == 6000)
    begin
      n_mismatch++;
      end_sim;
    end
  end

  // ==========================================================================
  // Test sequence.
  // ==========================================================================
  initial
  begin
    rail.code_max = 9'h1FF;
    rail.boot_code = 9'h0A0;
    rail.pg_on = 9'h050;
    rail.pg_off = 9'h040;
    rail.pg_delay_us = 8'h02;
    ph = '{p3: 8'h13, p4: 8'h24, p5: 8'h35, p6: 8'h46, p7: 8'h57};
    repeat (8) @(negedge i_sys_clk);
    i_rst = 1'b0;
    rd(CMD_SUMMARY_WORD, 16'h0040);
    rd(CMD_PHASE_34, 16'h2413);
    rd(CMD_PHASE_56, 16'h4635);
    rd(CMD_PHASE_7, 16'h0000);
    rail.phase7_on_rail = 1'b1;
    rd(CMD_PHASE_7, 16'h0057);
    host.xfer(8'h7C, r);
    chk(r, {2'b01, 16'h0057});
    rail.nvm_busy = 1'b1;
    rd(CMD_SUMMARY_BYTE, 16'h00C0);
    rail.nvm_busy = 1'b0;
    rd(CMD_SUMMARY_BYTE, 16'h0040);
    rail.enable = 1'b1;
    rail.code = 9'h080;
    rd(CMD_SUMMARY_BYTE, 16'h0000);
    rail.protect_off = 1'b1;
    rd(CMD_SUMMARY_BYTE, 16'h0040);
    rail.protect_off = 1'b0;
    rail.code = 9'h000;
    rd(CMD_SUMMARY_BYTE, 16'h0040);
    rail.code = 9'h080;
    // Each event is raised for one cycle and must stay latched until cleared.
    for (int i = 0; i < 16; i++)
    begin
      @(negedge i_sys_clk);
      ev_in = ev_tab[i];
      @(negedge i_sys_clk);
      chk({16'h0, o_monitor_reset, o_rail_shutdown},
        {16'h0, ev_tab[i][2], |ev_tab[i][1:0]});
      ev_in = '0;
      rd(CMD_SUMMARY_WORD, wd_tab[i]);
      rd(CMD_SUMMARY_BYTE, {8'h00, wd_tab[i][7:0]});
      rd(CMD_VOUT_DETAIL, {8'h00, vo_tab[i]});
      rd(CMD_IOUT_DETAIL, {8'h00, io_tab[i]});
      host.clear(r);
      chk({r[17:16], 16'h0}, 18'h0);
      rd(CMD_SUMMARY_WORD, 16'h0000);
      rd(CMD_VOUT_DETAIL, 16'h0000);
      rd(CMD_IOUT_DETAIL, 16'h0000);
    end
    // An event present at the clearing edge wins over the clear.
    ev_in.ov = 1'b1;
    host.clear(r);
    ev_in.ov = 1'b0;
    rd(CMD_VOUT_DETAIL, 16'h0080);
    host.clear(r);
    rail.code_max = 9'h07F;
    rd(CMD_VOUT_DETAIL, 16'h0008);
    rail.code_max = 9'h1FF;
    host.clear(r);
    rd(CMD_SUMMARY_WORD, 16'h0000);
    // Boot mode: ready follows reaching the boot level and drops when disabled.
    rail.vout_code = 9'h0A0;
    repeat (5) @(negedge i_sys_clk);
    rd(CMD_SUMMARY_WORD, 16'h0800);
    chk({17'h0, o_rail_ready_output}, 18'h1);
    rail.enable = 1'b0;
    repeat (5) @(negedge i_sys_clk);
    rd(CMD_SUMMARY_WORD, 16'h0040);
    // Threshold mode: ready only after two microseconds above the on level.
    rail.vout_code = 9'h000;
    rail.enable = 1'b1;
    rail.ready_mode = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    rail.vout_code = 9'h060;
    repeat (80) @(negedge i_sys_clk);
    rd(CMD_SUMMARY_WORD, 16'h0000);
    repeat (25) @(negedge i_sys_clk);
    rd(CMD_SUMMARY_WORD, 16'h0800);
    chk({17'h0, o_rail_ready_output}, 18'h1);
    rail.vout_code = 9'h040;
    repeat (5) @(negedge i_sys_clk);
    rd(CMD_SUMMARY_WORD, 16'h0000);
    end_sim;
  end
endmodule

// [rsp_host_model.sv]
`timescale 1ns/1ns
module rsp_host_model
(
  input wire logic i_sys_clk, // System clock.
  input wire logic [15:0] i_read_data, // Read data from the bank.
  input wire logic i_read_valid, // Read answered pulse.
  input wire logic i_cmd_unknown, // Refused code pulse.
  output logic o_cmd_valid, // Command strobe.
  output logic [7:0] o_cmd_code // Command code.
);
  import rsp_pkg::*;

  // ==========================================================================
  // Command issue.
  // ==========================================================================
  // The code line is idle between commands and carries no meaning then.
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
  end

  // The strobe stands for one cycle; the answer pulse also stands for one cycle only,
  // so it is taken half a cycle after the edge that launched it, before the strobe drops.
  // The code is inverted once released so a stale value is never mistaken for data.
  task automatic xfer(input logic [7:0] code, output logic [17:0] resp);
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b1;
    o_cmd_code = code;
    @(negedge i_sys_clk);
    resp = {i_read_valid, i_cmd_unknown, i_read_data};
    o_cmd_valid = 1'b0;
    o_cmd_code = ~code;
  endtask

  // Sending the clear code empties every latched flag in the bank, except a flag whose event is present at the clearing edge.
  task automatic clear(output logic [17:0] resp);
    xfer(CMD_CLEAR_FAULTS, resp);
  endtask
endmodule

// [rsp_pkg.sv]
package rsp_pkg;

  // ==========================================================================
  // Register command codes.
  // ==========================================================================
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_PHASE_34 = 8'h75;
  localparam logic [7:0] CMD_PHASE_56 = 8'h76;
  localparam logic [7:0] CMD_PHASE_7 = 8'h77;
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_DETAIL = 8'h7A;
  localparam logic [7:0] CMD_IOUT_DETAIL = 8'h7B;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int SB_NVM_BUSY = 7;
  localparam int SB_OFF = 6;
  localparam int SB_OV = 5;
  localparam int SB_OC = 4;
  localparam int SB_VIN_UV = 3;
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_IO_LOW = 12;
  localparam int SW_READY = 11;
  localparam int SW_WDOG = 8;
  localparam int VO_OV = 7;
  localparam int VO_UV_WARN = 5;
  localparam int VO_UV_FAULT = 4;
  localparam int VO_MAXMIN = 3;
  localparam int VO_FLOAT = 1;
  localparam int VO_GROUNDED = 0;
  localparam int IO_OC = 7;
  localparam int IO_OC_UV = 6;
  localparam int IO_OC_WARN = 5;
  localparam int IO_POUT_WARN = 0;

  // ==========================================================================
  // Reset values and timing.
  // ==========================================================================
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [8:0] ZERO_CODE = 9'h000;
  localparam int CLK_MHZ = 50;
  localparam int DELAY_UNIT_NS = 1000;
  localparam int CYC_PER_US = (DELAY_UNIT_NS * CLK_MHZ) / 1000;
  localparam logic [5:0] US_LAST = 6'(CYC_PER_US - 1);

  // Event inputs from the protection comparators and monitors.
  typedef struct packed {
    logic ov;
    logic oc;
    logic oc_warn;
    logic pout_warn;
    logic uv_warn;
    logic uv_fault;
    logic uv_comp;
    logic vin_uv;
    logic vin_other;
    logic ot;
    logic comm_memory_logic_flag;
    logic io_low;
    logic wdog_ovf;
    logic float_line;
    logic grounded;
  } rsp_events_t;

  // Live rail state and telemetry.
  typedef struct packed {
    logic nvm_busy;
    logic enable;
    logic protect_off;
    logic phase7_on_rail;
    logic [8:0] code;
    logic [8:0] code_max;
    logic [8:0] code_min;
    logic [8:0] vout_code;
    logic [8:0] boot_code;
    logic [8:0] pg_on;
    logic [8:0] pg_off;
    logic [7:0] pg_delay_us;
    logic ready_mode;
  } rsp_rail_t;

  typedef struct packed {
    logic [7:0] p3;
    logic [7:0] p4;
    logic [7:0] p5;
    logic [7:0] p6;
    logic [7:0] p7;
  } rsp_phase_t;

endpackage
